// >>> core/wlb_branch_eval.sv
/*
 * Decision logic of the software-pipelined loop branches: continue or exit,
 * counter decrements, rotation and the stage-enable value for the top predicate.
 * Purely combinational; the caller qualifies the outputs with its own strobe.
 */
`timescale 1ns/1ps

module wlb_branch_eval
    import wlb_pkg::*;
#(
    parameter int EC_W = 6
) (
    input wire wlb_kind_e kind,
    input wire logic br_pred,
    input wire logic [EC_W-1:0] ec,
    input wire logic lc_zero,
    output logic cont,
    output logic taken,
    output logic rot,
    output logic top_val,
    output logic ec_dec,
    output logic lc_dec
);

    // ----------------------------------------------------------------
    // Decision table
    // ----------------------------------------------------------------
    // A zero counter exits without rotating; this only happens in unrolled loops
    always_comb begin
        cont = 1'b0;
        rot = 1'b0;
        top_val = 1'b0;
        ec_dec = 1'b0;
        lc_dec = 1'b0;
        unique case (kind)
            WLB_WTOP, WLB_WEXIT: begin
                // Predicate and drain counter steer; the iteration counter is never looked at
                if (br_pred) begin
                    cont = 1'b1;
                    rot = 1'b1;
                end else if (ec > EC_W'(1)) begin
                    cont = 1'b1;
                    rot = 1'b1;
                    ec_dec = 1'b1;
                end else if (ec == EC_W'(1)) begin
                    rot = 1'b1;
                    ec_dec = 1'b1;
                end
                top_val = 1'b0;
            end
            WLB_CTOP: begin
                // Loop condition resolved in this single evaluation
                if (!lc_zero) begin
                    cont = 1'b1;
                    rot = 1'b1;
                    lc_dec = 1'b1;
                    top_val = 1'b1;
                end else if (ec > EC_W'(1)) begin
                    cont = 1'b1;
                    rot = 1'b1;
                    ec_dec = 1'b1;
                end else if (ec == EC_W'(1)) begin
                    rot = 1'b1;
                    ec_dec = 1'b1;
                end
            end
            default: begin
                cont = 1'b0;
            end
        endcase
    end

    // Exit-form branches are taken when the loop is left
    assign taken = (kind == WLB_WEXIT) ? !cont : cont;

endmodule

// >>> core/wlb_loop_ctrl.sv
/*
 * Loop-branch control: drain and iteration counters, rotating stage predicates,
 * rename base, compare write-back, and an Avalon-MM slave for software access.
 * Assumes core-side strobes arrive on MCLK; bus master follows Avalon waitrequest.
 */
// Behaviour
// - While branches never read or change the iteration counter.
// - The branch predicate selects between continue and drain/exit paths.
// - After every while branch the first stage predicate holds zero.
// - Predicate zero: continue only if drain counter above one; decrement it.
// - Exiting on predicate zero at count one still decrements counter and rotates once.
// - Each rotation decrements the rename base, shifting values one register up.
// - Rotation moves the first stage predicate into the second.
// - Without epilog stages the loop leaves as soon as predicate is zero.
// - Unconditional compare with false qualifier writes zero; conditional leaves target.
// - Counted top branch resolves the loop in one cycle via the iteration counter.
// - New stage-enable goes to the top predicate, rotating into the first.
`timescale 1ns/1ps

`include "wlb_regs.svh"

module wlb_loop_ctrl
    import wlb_pkg::*;
#(
    parameter int EC_W = 6,
    parameter int LC_W = 32,
    parameter int ROT_N = 48
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic BR_VALID,
    input wire logic [1:0] BR_KIND,
    input wire logic BR_PRED,
    input wire logic CMP_VALID,
    input wire logic CMP_UNC,
    input wire logic CMP_QP,
    input wire logic CMP_RESULT,
    input wire logic [5:0] CMP_TGT,
    output logic BR_DONE,
    output logic BR_TAKEN,
    output logic RRB_DEC,
    output logic FIRST_STAGE_PRED,
    output logic SECOND_STAGE_PRED,
    output logic [EC_W-1:0] DRAIN_COUNT,
    output logic [5:0] RENAME_BASE
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (ROT_N < 33 || ROT_N > 64) begin : g_bad_rot
        $error("ROT_N must lie between 33 and 64");
    end
    if (EC_W < 2 || EC_W > 32 || LC_W < 1 || LC_W > 32) begin : g_bad_w
        $error("EC_W must be 2..32 and LC_W 1..32");
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Rename base wraps inside the rotating region
    function automatic wlb_rrb_t rrb_dec(input wlb_rrb_t r);
        rrb_dec = (r == 6'h00) ? 6'(ROT_N - 1) : r - 6'h01;
    endfunction

    // Byte-lane merge for partial writes
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        be_merge = m;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [EC_W-1:0] ec_q;
    logic [LC_W-1:0] lc_q;
    logic [ROT_N-1:0] rot_q;
    logic [ROT_N-1:0] rot_d;
    logic [ROT_N-1:0] cmp_rot;
    wlb_rrb_t rrb_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic last_cont_q;
    logic exited_q;
    logic done_q;
    logic taken_q;
    logic rrb_dec_q;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic [63:0] pred64;
    logic bus_req;
    logic wr_en;
    logic pred_wr;
    logic op;
    logic op_while;
    wlb_kind_e kind;
    logic ev_cont;
    logic ev_taken;
    logic ev_rot;
    logic ev_top;
    logic ev_ec_dec;
    logic ev_lc_dec;

    // ----------------------------------------------------------------
    // Core strobes and branch evaluation
    // ----------------------------------------------------------------
    assign kind = wlb_kind_e'(BR_KIND);
    assign op = BR_VALID && CLK_EN && (BR_KIND != 2'b11);
    assign op_while = op && (kind == WLB_WTOP || kind == WLB_WEXIT);

    wlb_branch_eval #(
        .EC_W(EC_W)
    ) u_eval (
        .kind(kind),
        .br_pred(BR_PRED),
        .ec(ec_q),
        .lc_zero(lc_q == '0),
        .cont(ev_cont),
        .taken(ev_taken),
        .rot(ev_rot),
        .top_val(ev_top),
        .ec_dec(ev_ec_dec),
        .lc_dec(ev_lc_dec)
    );

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait state on every access while CLK_EN is high
    // ----------------------------------------------------------------
    assign bus_req = AVS_READ || AVS_WRITE;
    // Gating with the enable keeps a frozen block from completing a transfer
    assign AVS_WAITREQUEST = bus_req && !(ack_q && CLK_EN);
    assign wr_en = AVS_WRITE && ack_q && CLK_EN;
    assign pred_wr = wr_en && (AVS_ADDRESS[4:2] == `WLB_OFS_PRED_LO >> 2 ||
                               AVS_ADDRESS[4:2] == `WLB_OFS_PRED_HI >> 2);
    assign pred64 = 64'(rot_q);
    assign AVS_READDATA = rdata_q;

    // Read mux, also the base for byte-lane merges; unmapped words read zero
    always_comb begin
        unique case ({AVS_ADDRESS[4:2], 2'b00})
            `WLB_OFS_DRAIN: rd_word = 32'(ec_q);
            `WLB_OFS_ITER: rd_word = 32'(lc_q);
            `WLB_OFS_PRED_LO: rd_word = pred64[31:0];
            `WLB_OFS_PRED_HI: rd_word = pred64[63:32];
            `WLB_OFS_RENAME: rd_word = 32'(rrb_q);
            `WLB_OFS_STATUS: rd_word = {30'h0, exited_q, last_cont_q};
            default: rd_word = 32'h0000_0000;
        endcase
    end
    assign wr_word = be_merge(rd_word, AVS_WRITEDATA, AVS_BYTEENABLE);

    // Acknowledge toggles so each request sees exactly one wait cycle while CLK_EN is high
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (CLK_EN) begin
            ack_q <= bus_req && !ack_q;
            if (AVS_READ && !ack_q) begin
                rdata_q <= rd_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // Drain stage counter
    // ----------------------------------------------------------------
    // Software write wins over a decrement in the same cycle
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ec_q <= EC_W'(`WLB_RST_DRAIN);
        end else if (CLK_EN) begin
            if (wr_en && AVS_ADDRESS[4:2] == `WLB_OFS_DRAIN >> 2) begin
                ec_q <= wr_word[EC_W-1:0];
            end else if (op && ev_ec_dec) begin
                ec_q <= ec_q - EC_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Iteration counter: only the counted branch touches it
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lc_q <= LC_W'(`WLB_RST_ITER);
        end else if (CLK_EN) begin
            if (wr_en && AVS_ADDRESS[4:2] == `WLB_OFS_ITER >> 2) begin
                lc_q <= wr_word[LC_W-1:0];
            end else if (op && ev_lc_dec && kind == WLB_CTOP) begin
                lc_q <= lc_q - LC_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Rotating predicates: compare write-back, then rotation
    // ----------------------------------------------------------------
    // A compare in the same cycle lands before the branch rotates it away
    always_comb begin
        cmp_rot = rot_q;
        if (CMP_VALID && 32'(CMP_TGT) < ROT_N) begin
            if (CMP_QP) begin
                cmp_rot[CMP_TGT] = CMP_RESULT;
            end else if (CMP_UNC) begin
                cmp_rot[CMP_TGT] = 1'b0;
            end
        end
    end

    // Top predicate takes the new enable; the rotate carries it into stage one
    always_comb begin
        rot_d = cmp_rot;
        if (op && ev_rot) begin
            rot_d[ROT_N-1] = ev_top;
            rot_d = {rot_d[ROT_N-2:0], rot_d[ROT_N-1]};
        end else if (op_while) begin
            rot_d[0] = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rot_q <= '0;
        end else if (CLK_EN) begin
            if (pred_wr && AVS_ADDRESS[4:2] == `WLB_OFS_PRED_LO >> 2) begin
                rot_q[31:0] <= wr_word;
            end else if (pred_wr) begin
                rot_q[ROT_N-1:32] <= wr_word[ROT_N-33:0];
            end else begin
                rot_q <= rot_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // Rename base
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rrb_q <= `WLB_RST_RENAME;
            rrb_dec_q <= 1'b0;
        end else if (CLK_EN) begin
            rrb_dec_q <= op && ev_rot;
            if (op && ev_rot) begin
                rrb_q <= rrb_dec(rrb_q);
            end
        end
    end

    // ----------------------------------------------------------------
    // Branch result and status
    // ----------------------------------------------------------------
    // Exit flag is sticky; a new exit beats a write-one-to-clear
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            done_q <= 1'b0;
            taken_q <= 1'b0;
            last_cont_q <= 1'b0;
            exited_q <= 1'b0;
        end else if (CLK_EN) begin
            done_q <= op;
            taken_q <= op && ev_taken;
            if (op) begin
                last_cont_q <= ev_cont;
            end
            if (op && !ev_cont) begin
                exited_q <= 1'b1;
            end else if (wr_en && AVS_ADDRESS[4:2] == `WLB_OFS_STATUS >> 2 &&
                         wr_word[`WLB_STAT_EXIT_BIT]) begin
                exited_q <= 1'b0;
            end
        end
    end

    assign BR_DONE = done_q;
    assign BR_TAKEN = taken_q;
    assign RRB_DEC = rrb_dec_q;
    assign FIRST_STAGE_PRED = rot_q[0];
    assign SECOND_STAGE_PRED = rot_q[1];
    assign DRAIN_COUNT = ec_q;
    assign RENAME_BASE = rrb_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_iter_kept;
        @(posedge MCLK) disable iff (!ARST_N)
        (op_while && !wr_en) |=> (lc_q == $past(lc_q));
    endproperty
    a_iter_kept: assert property (p_iter_kept)
        else $error("while branch changed iteration counter");

    property p_pred_one;
        @(posedge MCLK) disable iff (!ARST_N)
        (op_while && BR_PRED && !wr_en) |=> (ec_q == $past(ec_q)) && RRB_DEC && last_cont_q;
    endproperty
    a_pred_one: assert property (p_pred_one)
        else $error("predicate one did not continue with counter kept");

    property p_drain_cont;
        @(posedge MCLK) disable iff (!ARST_N)
        (op_while && !BR_PRED && ec_q > EC_W'(1) && !wr_en)
            |=> (ec_q == $past(ec_q) - EC_W'(1)) && last_cont_q && BR_DONE;
    endproperty
    a_drain_cont: assert property (p_drain_cont)
        else $error("drain path did not continue and decrement");

    property p_final_exit;
        @(posedge MCLK) disable iff (!ARST_N)
        (op_while && !BR_PRED && ec_q == EC_W'(1) && !wr_en)
            |=> (ec_q == '0) && RRB_DEC && !last_cont_q && exited_q;
    endproperty
    a_final_exit: assert property (p_final_exit)
        else $error("final exit missed decrement or rotation");

    property p_first_zero;
        @(posedge MCLK) disable iff (!ARST_N)
        (op_while && !pred_wr) |=> !FIRST_STAGE_PRED;
    endproperty
    a_first_zero: assert property (p_first_zero)
        else $error("first stage predicate not zero after while branch");

    property p_pass_down;
        @(posedge MCLK) disable iff (!ARST_N)
        (op && ev_rot && !pred_wr) |=> (SECOND_STAGE_PRED == $past(cmp_rot[0]));
    endproperty
    a_pass_down: assert property (p_pass_down)
        else $error("stage one value did not reach stage two");

    property p_rename;
        @(posedge MCLK) disable iff (!ARST_N)
        (op && ev_rot) |=> RRB_DEC && (RENAME_BASE == rrb_dec($past(RENAME_BASE)));
    endproperty
    a_rename: assert property (p_rename)
        else $error("rename base not decremented on rotation");

    property p_unc_zero;
        @(posedge MCLK) disable iff (!ARST_N)
        (CLK_EN && CMP_VALID && !CMP_QP && CMP_UNC && 32'(CMP_TGT) < ROT_N && !op && !pred_wr)
            |=> !rot_q[$past(CMP_TGT)];
    endproperty
    a_unc_zero: assert property (p_unc_zero)
        else $error("unconditional compare did not clear target");

    property p_counted_set;
        @(posedge MCLK) disable iff (!ARST_N)
        (op && kind == WLB_CTOP && lc_q != '0 && !pred_wr) |=> FIRST_STAGE_PRED && BR_TAKEN;
    endproperty
    a_counted_set: assert property (p_counted_set)
        else $error("counted branch did not set stage one");

    property p_top_lands;
        @(posedge MCLK) disable iff (!ARST_N)
        (op && kind == WLB_CTOP && lc_q == '0 && ec_q > EC_W'(1) && !pred_wr)
            |=> !FIRST_STAGE_PRED && (rot_q[ROT_N-1] == $past(cmp_rot[ROT_N-2]));
    endproperty
    a_top_lands: assert property (p_top_lands)
        else $error("top predicate value did not rotate into stage one");

    property p_no_epilog;
        @(posedge MCLK) disable iff (!ARST_N)
        (op_while && !BR_PRED && ec_q <= EC_W'(1)) |=> !last_cont_q ##1 1'b1;
    endproperty
    a_no_epilog: assert property (p_no_epilog)
        else $error("loop kept running after predicate turned zero");

endmodule

// >>> core/wlb_pkg.sv
/*
 * Types shared by the loop-branch control block.
 * Assumes nothing of its surroundings.
 */
package wlb_pkg;

    // Branch kinds presented by the core; code 2'b11 is illegal
    typedef enum logic [1:0] {
        WLB_WTOP = 2'b00,
        WLB_WEXIT = 2'b01,
        WLB_CTOP = 2'b10
    } wlb_kind_e;

    typedef logic [5:0] wlb_rrb_t;

endpackage

// >>> core/wlb_regs.svh
/*
 * Register offsets, reset values and field positions of the loop-branch control block.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef WLB_REGS_SVH
`define WLB_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------
`define WLB_OFS_DRAIN 5'h00
`define WLB_OFS_ITER 5'h04
`define WLB_OFS_PRED_LO 5'h08
`define WLB_OFS_PRED_HI 5'h0c
`define WLB_OFS_RENAME 5'h10
`define WLB_OFS_STATUS 5'h14

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define WLB_STAT_CONT_BIT 0
`define WLB_STAT_EXIT_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WLB_RST_DRAIN 6'h00
`define WLB_RST_ITER 32'h0000_0000
`define WLB_RST_RENAME 6'h00

`endif

// >>> test/tb.sv
/*
 * Self-checking bench for the loop-branch control block: bus, branch and compare ports.
 * Assumes the block answers each bus request after one wait state, as its note says.
 */
`timescale 1ns/1ps

`include "wlb_regs.svh"

module tb
    import wlb_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and clocking
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic br_v = 1'b0;
    logic [1:0] br_k = 2'h0;
    logic br_p = 1'b0;
    logic cmp_v = 1'b0;
    logic cmp_u = 1'b0;
    logic cmp_q = 1'b0;
    logic cmp_r = 1'b0;
    logic [5:0] cmp_t = 6'h00;
    logic [31:0] rdat;
    logic wait_r;
    logic done;
    logic taken;
    logic rrb_dec;
    logic fsp;
    logic ssp;
    logic [5:0] drain;
    logic [5:0] rbase;
    int bad_count = 0;
    int n_checks = 0;
    logic [31:0] got;

    // 125 MHz core clock
    always #4 mclk = ~mclk;

    wlb_loop_ctrl #(.EC_W(6), .LC_W(32), .ROT_N(48)) i_wlb_loop_ctrl (
        .MCLK(mclk), .ARST_N(arst_n), .CLK_EN(clk_en),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r),
        .BR_VALID(br_v), .BR_KIND(br_k), .BR_PRED(br_p),
        .CMP_VALID(cmp_v), .CMP_UNC(cmp_u), .CMP_QP(cmp_q), .CMP_RESULT(cmp_r),
        .CMP_TGT(cmp_t), .BR_DONE(done), .BR_TAKEN(taken), .RRB_DEC(rrb_dec),
        .FIRST_STAGE_PRED(fsp), .SECOND_STAGE_PRED(ssp),
        .DRAIN_COUNT(drain), .RENAME_BASE(rbase)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        adr <= a;
        wdat <= d;
        rd <= ~is_wr;
        wr <= is_wr;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (wait_r === 1'b0) begin
                break;
            end
        end
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        // Let the completing edge settle before callers look at outputs
        #1;
        if (n == 20) begin
            bad_count++;
            tally_and_finish();
        end
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(got, exp);
    endtask

    // One branch pulse; the answer pulses are looked at in the cycle after the taking edge
    task automatic br(input logic [1:0] k, input logic p, input logic [2:0] exp_dtr);
        @(posedge mclk);
        br_v <= 1'b1;
        br_k <= k;
        br_p <= p;
        @(posedge mclk);
        br_v <= 1'b0;
        #1;
        chk({29'h0, done, taken, rrb_dec}, {29'h0, exp_dtr});
    endtask

    task automatic st(input logic [5:0] dc, input logic [5:0] rb, input logic f, input logic s);
        chk({20'h0, drain, rbase}, {20'h0, dc, rb});
        chk({30'h0, fsp, ssp}, {30'h0, f, s});
    endtask

    task automatic cmp(input logic u, input logic q, input logic r, input logic [5:0] t);
        @(posedge mclk);
        {cmp_v, cmp_u, cmp_q, cmp_r, cmp_t} <= {1'b1, u, q, r, t};
        @(posedge mclk);
        cmp_v <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        st(6'h00, 6'h00, 1'b0, 1'b0);
        rd_chk(5'h18, 32'h0);
        bus(1'b1, `WLB_OFS_RENAME, 32'h5);
        rd_chk(`WLB_OFS_RENAME, 32'h0);
        bus(1'b1, `WLB_OFS_ITER, 32'h5);
        bus(1'b1, `WLB_OFS_DRAIN, 32'h2);
        bus(1'b1, `WLB_OFS_PRED_LO, 32'h1);
        chk({31'h0, fsp}, 32'h1);
        // Prolog: predicate zero with two stages left keeps the loop going
        br(WLB_WTOP, 1'b0, 3'b111);
        st(6'h01, 6'h2f, 1'b0, 1'b1);
        rd_chk(`WLB_OFS_ITER, 32'h5);
        rd_chk(`WLB_OFS_PRED_LO, 32'h2);
        // Kernel: predicate one leaves the drain counter alone
        br(WLB_WTOP, 1'b1, 3'b111);
        st(6'h01, 6'h2e, 1'b0, 1'b0);
        rd_chk(`WLB_OFS_PRED_LO, 32'h4);
        // No epilog: predicate zero at count one falls out after a last rotation
        br(WLB_WTOP, 1'b0, 3'b101);
        st(6'h00, 6'h2d, 1'b0, 1'b0);
        rd_chk(`WLB_OFS_STATUS, 32'h2);
        // Count already zero: exit without rotating
        br(WLB_WTOP, 1'b0, 3'b100);
        st(6'h00, 6'h2d, 1'b0, 1'b0);
        // Exit form: not taken while the loop continues
        bus(1'b1, `WLB_OFS_DRAIN, 32'h3);
        br(WLB_WEXIT, 1'b1, 3'b101);
        st(6'h03, 6'h2c, 1'b0, 1'b0);
        br(WLB_WEXIT, 1'b0, 3'b101);
        st(6'h02, 6'h2b, 1'b0, 1'b0);
        // Counted form sets the first stage and uses the iteration counter
        br(WLB_CTOP, 1'b0, 3'b111);
        st(6'h02, 6'h2a, 1'b1, 1'b0);
        rd_chk(`WLB_OFS_ITER, 32'h4);
        // Illegal kind is ignored
        br(2'b11, 1'b0, 3'b000);
        st(6'h02, 6'h2a, 1'b1, 1'b0);
        // Compares: with a false qualifier conditional keeps and unconditional clears; a true one writes the result
        cmp(1'b0, 1'b0, 1'b0, 6'h00);
        chk({31'h0, fsp}, 32'h1);
        cmp(1'b1, 1'b0, 1'b1, 6'h00);
        chk({31'h0, fsp}, 32'h0);
        cmp(1'b0, 1'b1, 1'b1, 6'h01);
        chk({31'h0, ssp}, 32'h1);
        // Frozen clock enable: a branch pulse is not taken
        @(posedge mclk);
        {clk_en, br_v, br_k, br_p} <= {1'b0, 1'b1, 2'b00, 1'b0};
        @(posedge mclk);
        {clk_en, br_v} <= {1'b1, 1'b0};
        repeat (2) @(posedge mclk);
        st(6'h02, 6'h2a, 1'b0, 1'b1);
        // Counted form with the iteration counter spent drains with stage one off
        bus(1'b1, `WLB_OFS_ITER, 32'h0);
        br(WLB_CTOP, 1'b0, 3'b111);
        st(6'h01, 6'h29, 1'b0, 1'b0);
        // Exit flag clears on a written one; the last decision bit stays
        bus(1'b1, `WLB_OFS_STATUS, 32'h2);
        rd_chk(`WLB_OFS_STATUS, 32'h1);
        tally_and_finish();
    end
endmodule
